/* src/sfw_buf.sv */
// sfw_buf.sv: small buffer between byte decoder and memory write port
// assumes: same clock on both sides, sink may stall
`timescale 1ns/10ps
`default_nettype none
module sfw_buf import sfw_pkg::*; #(
    parameter int DEPTH = 2
) (
    input  wire logic   i_mclk,  // system clock
    input  wire logic   i_rst_n, // async reset, active low
    sfw_push_if.sink    push,    // filling side
    output logic        o_valid, // word available
    output sfw_word_type o_word, // head word
    input  wire logic   i_ready  // drain side accepts
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    sfw_word_type  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          do_push;
    logic          do_pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push.ready = (count != (AW + 1)'(DEPTH));
    assign o_valid    = (count != '0);
    assign o_word     = mem[rd_ptr];
    assign do_push    = push.valid & push.ready;
    assign do_pop     = o_valid & i_ready;

    always_ff @(posedge i_mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push.word;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            count <= count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
        end
    end

    property p_buf_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (o_valid && !i_ready) |=> (o_valid && o_word == $past(o_word));
    endproperty
    a_buf_hold: assert property (p_buf_hold)
        else $error("buffered word changed while stalled");
endmodule
`default_nettype wire

/* src/sfw_defines.svh */
// sfw_defines.svh: opcodes, mode patterns and address limits of the
// serial write command decoder
// assumes: included by bare name from the package and the top module
// Functional notes
// - plain write 02h uses one, two or four lanes per protocol
// - burst bytes go to successive addresses while select stays low
// - address 3FFFFh rolls over to 00000h and writing continues
// - a write executes only with the write enable latch set
// - the write enable latch is never cleared by a write
// - dual-edge write DEh samples address and data on both edges
// - dual-edge commands work in clock mode 0 only, not mode 3
// - mode byte 1010xxxx enters continuous mode, next frame skips opcode
// - other mode byte leaves continuous mode, opcode needed again
// - dual-edge continuous write DDh enters continuous mode on A5h only
// - on DDh any mode byte but A5h leaves continuous mode
// - A2h sends opcode, address, mode on one lane, data on two
// - A1h sends opcode on one lane, address, mode and data on two
// - 32h sends opcode, address, mode on one lane, data on four
// - only address bits 17..0 decode, 23..18 are ignored
// - protected addresses keep incrementing but store nothing
`ifndef SFW_DEFINES_SVH
`define SFW_DEFINES_SVH
`define SFW_OP_WRITE     8'h02
`define SFW_OP_DE_WRITE  8'hDE
`define SFW_OP_FAST      8'hDA
`define SFW_OP_DE_FAST   8'hDD
`define SFW_OP_TWO_DATA  8'hA2
`define SFW_OP_TWO_AD    8'hA1
`define SFW_OP_FOUR_DATA 8'h32
`define SFW_MODE_NIB     4'hA
`define SFW_MODE_DE      8'hA5
`define SFW_ADDR_MAX     18'h3FFFF
`define SFW_ADDR_ZERO    18'h00000
`define SFW_ADDR_LAST    2'h2
`define SFW_BYTE_BITS    4'h8
`define SFW_PIN_INIT     6'h20
`endif

/* src/sfw_pkg.sv */
// sfw_pkg.sv: types of the serial write command decoder
// assumes: sfw_defines.svh is on the include path
package sfw_pkg;
`include "sfw_defines.svh"
    typedef enum logic [2:0] {
        sfw_ph_idle, sfw_ph_opc, sfw_ph_addr,
        sfw_ph_mode, sfw_ph_data, sfw_ph_skip
    } sfw_phase_type;
    typedef enum logic [1:0] {
        sfw_lane1, sfw_lane2, sfw_lane4
    } sfw_lane_type;
    typedef struct packed {
        logic [17:0] addr;
        logic [7:0]  data;
    } sfw_word_type;
endpackage

/* src/sfw_push_if.sv */
// sfw_push_if.sv: byte push handshake from decoder into the buffer
// assumes: both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface sfw_push_if;
    import sfw_pkg::*;
    logic         valid;
    logic         ready;
    sfw_word_type word;
    modport src  (output valid, output word, input ready);
    modport sink (input valid, input word, output ready);
endinterface
`default_nettype wire

/* src/sfw_sync.sv */
// sfw_sync.sv: two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to i_mclk
`timescale 1ns/10ps
`default_nettype none
module sfw_sync #(
    parameter int              W    = 6,
    parameter logic [W-1:0]    INIT = '0
) (
    input  wire logic          i_mclk,  // system clock
    input  wire logic          i_rst_n, // async reset, active low
    input  wire logic [W-1:0]  i_d,     // raw pins
    output logic      [W-1:0]  o_q      // synchronised pins
);
    logic [W-1:0] meta;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= INIT;
            o_q  <= INIT;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule
`default_nettype wire

/* src/sfw_top.sv */
// sfw_top.sv: write command decoder of a serial memory device
// assumes: pins arrive asynchronously; write latch, protection and
// lane protocol come from logic on i_mclk
`timescale 1ns/10ps
`default_nettype none
`include "sfw_defines.svh"
module sfw_top import sfw_pkg::*; #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic         i_mclk,     // system clock
    input  wire logic         i_rst_n,    // async reset, active low
    input  wire logic         i_cs_n,     // chip select pin, low active
    input  wire logic         i_sck,      // serial clock pin
    input  wire logic [3:0]   i_io,       // lanes 3..0 (0 = serial in)
    input  wire sfw_lane_type i_proto,    // lane protocol in force
    input  wire logic         i_write_enable_latch, // latch state
    input  wire logic         i_wr_prot,  // o_wr_addr is protected
    input  wire logic         i_wr_ready, // memory accepts a byte
    output logic              o_wr_valid, // byte write request
    output logic [17:0]       o_wr_addr,  // byte address
    output logic [7:0]        o_wr_data,  // byte value
    output logic              o_cont,     // continuous mode active
    output logic              o_overrun   // byte lost to full buffer
);
    // ----------------------------------------------------------
    // pin sampling and edge detection
    // ----------------------------------------------------------
    logic [5:0]    pins;
    logic          s_cs_n;
    logic          s_sck;
    logic [3:0]    s_io;
    logic          cs_d;
    logic          sck_d;
    logic          cs_fall;
    logic          sck_rise;
    logic          sck_fall;

    sfw_sync #(.W(6), .INIT(`SFW_PIN_INIT)) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_cs_n, i_sck, i_io}),
        .o_q     (pins)
    );
    assign s_cs_n = pins[5];
    assign s_sck  = pins[4];
    assign s_io   = pins[3:0];

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_d  <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_d  <= s_cs_n;
            sck_d <= s_sck;
        end
    end
    assign cs_fall  = cs_d & ~s_cs_n;
    assign sck_rise = ~s_cs_n & ~cs_fall & ~sck_d & s_sck;
    assign sck_fall = ~s_cs_n & ~cs_fall & sck_d & ~s_sck;

    // ----------------------------------------------------------
    // command helpers
    // ----------------------------------------------------------
    function automatic logic op_known(input logic [7:0] op);
        return op == `SFW_OP_WRITE || op == `SFW_OP_DE_WRITE ||
               op == `SFW_OP_FAST || op == `SFW_OP_DE_FAST ||
               op == `SFW_OP_TWO_DATA || op == `SFW_OP_TWO_AD ||
               op == `SFW_OP_FOUR_DATA;
    endfunction

    function automatic logic op_ddr(input logic [7:0] op);
        return op == `SFW_OP_DE_WRITE || op == `SFW_OP_DE_FAST;
    endfunction

    function automatic logic op_mode(input logic [7:0] op);
        return op == `SFW_OP_FAST || op == `SFW_OP_DE_FAST ||
               op == `SFW_OP_TWO_DATA || op == `SFW_OP_TWO_AD ||
               op == `SFW_OP_FOUR_DATA;
    endfunction

    function automatic logic mode_ok(input logic [7:0] op,
                                     input logic [7:0] mb);
        if (op == `SFW_OP_DE_FAST) begin
            return mb == `SFW_MODE_DE;
        end
        return mb[7:4] == `SFW_MODE_NIB;
    endfunction

    function automatic logic [17:0] addr_inc(input logic [17:0] a);
        return (a == `SFW_ADDR_MAX) ? `SFW_ADDR_ZERO : a + 18'h00001;
    endfunction

    // ----------------------------------------------------------
    // decoder state
    // ----------------------------------------------------------
    sfw_phase_type phase;
    sfw_lane_type  lane;
    logic [7:0]    cmd;
    logic [7:0]    cont_cmd;
    logic [7:0]    sr;
    logic [7:0]    next_sr;
    logic [3:0]    bitcnt;
    logic [3:0]    next_cnt;
    logic [3:0]    step;
    logic [1:0]    bytecnt;
    logic [17:0]   addr;
    logic          en;
    logic          start_hi;
    logic          ddr;
    logic          sample;
    logic          byte_done;
    sfw_push_if    push ();

    always_comb begin
        lane = sfw_lane1;
        if (i_proto != sfw_lane1) begin
            lane = i_proto;
        end else if (phase != sfw_ph_opc) begin
            case (cmd)
                `SFW_OP_TWO_DATA: begin
                    if (phase == sfw_ph_data) lane = sfw_lane2;
                end
                `SFW_OP_TWO_AD: begin
                    lane = sfw_lane2;
                end
                `SFW_OP_FOUR_DATA: begin
                    if (phase == sfw_ph_data) lane = sfw_lane4;
                end
                default: begin
                    lane = sfw_lane1;
                end
            endcase
        end
    end

    always_comb begin
        case (lane)
            sfw_lane4: begin
                next_sr = {sr[3:0], s_io};
                step    = 4'h4;
            end
            sfw_lane2: begin
                next_sr = {sr[5:0], s_io[1:0]};
                step    = 4'h2;
            end
            default: begin
                next_sr = {sr[6:0], s_io[0]};
                step    = 4'h1;
            end
        endcase
    end

    assign ddr = op_ddr(cmd) && (phase == sfw_ph_addr ||
                 phase == sfw_ph_mode || phase == sfw_ph_data);
    assign sample    = sck_rise | (ddr & sck_fall);
    assign next_cnt  = bitcnt + step;
    assign byte_done = sample && next_cnt == `SFW_BYTE_BITS &&
                       phase != sfw_ph_idle && phase != sfw_ph_skip;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr     <= 8'h00;
            bitcnt <= 4'h0;
        end else if (cs_fall || byte_done) begin
            bitcnt <= 4'h0;
        end else if (sample) begin
            sr     <= next_sr;
            bitcnt <= next_cnt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase    <= sfw_ph_idle;
            cmd      <= 8'h00;
            bytecnt  <= 2'h0;
            en       <= 1'b0;
            start_hi <= 1'b0;
        end else if (s_cs_n) begin
            phase <= sfw_ph_idle;
        end else if (cs_fall) begin
            bytecnt  <= 2'h0;
            start_hi <= s_sck;
            if (o_cont) begin
                phase <= sfw_ph_addr;
                cmd   <= cont_cmd;
                en    <= i_write_enable_latch;
                if (op_ddr(cont_cmd) && s_sck) phase <= sfw_ph_skip;
            end else begin
                phase <= sfw_ph_opc;
            end
        end else if (byte_done) begin
            case (phase)
                sfw_ph_opc: begin
                    cmd <= next_sr;
                    en  <= i_write_enable_latch;
                    if (!op_known(next_sr) ||
                        (op_ddr(next_sr) && start_hi)) begin
                        phase <= sfw_ph_skip;
                    end else begin
                        phase <= sfw_ph_addr;
                    end
                end
                sfw_ph_addr: begin
                    bytecnt <= bytecnt + 2'h1;
                    if (bytecnt == `SFW_ADDR_LAST) begin
                        phase <= op_mode(cmd) ? sfw_ph_mode
                                              : sfw_ph_data;
                    end
                end
                sfw_ph_mode: begin
                    phase <= sfw_ph_data;
                end
                default: begin
                    phase <= phase;
                end
            endcase
        end
    end

    // address keeps only bits 17..0; bits 23..18 shift out unused
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr <= `SFW_ADDR_ZERO;
        end else if (byte_done && phase == sfw_ph_addr) begin
            addr <= {addr[9:0], next_sr};
        end else if (byte_done && phase == sfw_ph_data) begin
            addr <= addr_inc(addr);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cont   <= 1'b0;
            cont_cmd <= 8'h00;
        end else if (byte_done && phase == sfw_ph_mode) begin
            o_cont   <= mode_ok(cmd, next_sr);
            cont_cmd <= cmd;
        end
    end

    // ----------------------------------------------------------
    // byte path: buffer, protection and write port
    // ----------------------------------------------------------
    logic buf_valid;
    sfw_word_type buf_word;

    // latch state is an input only; nothing here clears it
    assign push.valid = byte_done && phase == sfw_ph_data && en;
    assign push.word  = '{addr: addr, data: next_sr};

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_overrun <= 1'b0;
        end else if (push.valid && !push.ready) begin
            o_overrun <= 1'b1;
        end else if (cs_fall) begin
            o_overrun <= 1'b0;
        end
    end

    sfw_buf #(.DEPTH(BUF_DEPTH)) u_buf (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .push    (push),
        .o_valid (buf_valid),
        .o_word  (buf_word),
        .i_ready (i_wr_ready | i_wr_prot)
    );
    assign o_wr_valid = buf_valid & ~i_wr_prot;
    assign o_wr_addr  = buf_word.addr;
    assign o_wr_data  = buf_word.data;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    logic [17:0] prev_addr;
    logic        have_prev;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_addr <= `SFW_ADDR_ZERO;
            have_prev <= 1'b0;
        end else if (cs_fall) begin
            have_prev <= 1'b0;
        end else if (push.valid) begin
            prev_addr <= push.word.addr;
            have_prev <= 1'b1;
        end
    end

    property p_plain_lane;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cmd == `SFW_OP_WRITE && phase == sfw_ph_data) |-> lane == i_proto;
    endproperty
    a_plain_lane: assert property (p_plain_lane)
        else $error("plain write used wrong lane count");

    property p_burst_next;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (push.valid && have_prev) |-> push.word.addr == addr_inc(prev_addr);
    endproperty
    a_burst_next: assert property (p_burst_next)
        else $error("burst byte not at next address");

    property p_roll;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (byte_done && phase == sfw_ph_data && addr == `SFW_ADDR_MAX)
        |=> addr == `SFW_ADDR_ZERO;
    endproperty
    a_roll: assert property (p_roll)
        else $error("address did not roll over");

    property p_latch_gate;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_opc && byte_done && !i_write_enable_latch)
        |=> !en;
    endproperty
    a_latch_gate: assert property (p_latch_gate)
        else $error("frame enabled with latch clear");

    property p_no_write_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_data && !en) |-> !push.valid;
    endproperty
    a_no_write_clear: assert property (p_no_write_clear)
        else $error("write issued with latch clear");

    property p_both_edges;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (op_ddr(cmd) && phase == sfw_ph_data && sck_fall) |-> sample;
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("dual-edge write missed falling edge");

    property p_mode3;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_opc && byte_done && op_ddr(next_sr) && start_hi)
        |=> phase == sfw_ph_skip;
    endproperty
    a_mode3: assert property (p_mode3)
        else $error("dual-edge command accepted in mode 3");

    property p_cont_enter;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_mode && byte_done && cmd != `SFW_OP_DE_FAST &&
         next_sr[7:4] == `SFW_MODE_NIB) |=> o_cont ##1 1'b1;
    endproperty
    a_cont_enter: assert property (p_cont_enter)
        else $error("continuous mode not entered");

    property p_cont_skip;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cs_fall && o_cont && !(op_ddr(cont_cmd) && s_sck))
        |=> phase == sfw_ph_addr && bytecnt == 2'h0;
    endproperty
    a_cont_skip: assert property (p_cont_skip)
        else $error("continuous frame did not start at address");

    property p_de_exact;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_mode && byte_done && cmd == `SFW_OP_DE_FAST)
        |=> o_cont == ($past(next_sr) == `SFW_MODE_DE);
    endproperty
    a_de_exact: assert property (p_de_exact)
        else $error("dual-edge mode byte decoded wrongly");

    property p_cont_exit;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (phase == sfw_ph_mode && byte_done && cmd != `SFW_OP_DE_FAST &&
         next_sr[7:4] != `SFW_MODE_NIB) |=> !o_cont;
    endproperty
    a_cont_exit: assert property (p_cont_exit)
        else $error("continuous mode not left");

    property p_split_lanes;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_proto == sfw_lane1 && phase == sfw_ph_data &&
         cmd == `SFW_OP_FOUR_DATA) |-> lane == sfw_lane4;
    endproperty
    a_split_lanes: assert property (p_split_lanes)
        else $error("four-lane data not on four lanes");

    property p_prot_drop;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (buf_valid && i_wr_prot) |-> !o_wr_valid ##1 1'b1;
    endproperty
    a_prot_drop: assert property (p_prot_drop)
        else $error("protected byte offered to memory");
endmodule
`default_nettype wire

/* tb/sfw_host.sv */
// sfw_host.sv: host side of the serial link, framing and lane shifting
// assumes: tasks are called by the bench; link clock period 125 ns
`timescale 1ns/10ps
`default_nettype none
module sfw_host (
    output logic       o_cs_n, // chip select, low active
    output logic       o_sck,  // serial clock
    output logic [3:0] o_io    // lanes 3..0
);
    // ------------------------------------------------
    // framing
    // ------------------------------------------------
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_io   = 4'h0;
    end
    // clock idles low for mode 0, high for mode 3
    task automatic open_frame(input bit m3);
        o_sck = m3;
        #20;
        o_cs_n = 1'b0;
        #62.5;
    endtask
    // msb first; unused lanes toggle
    task automatic shift(input logic [23:0] v, input int n, input int ln,
                         input bit ddr);
        int k;
        logic [23:0] s;
        s = v;
        for (k = 0; k < n; k += ln) begin
            if (!ddr && o_sck) begin
                #31.25;
                o_sck = 1'b0;
            end
            o_io = ~o_io;
            if (ln == 4) o_io = s[23:20];
            else if (ln == 2) o_io[1:0] = s[23:22];
            else o_io[0] = s[23];
            s = s << ln;
            if (ddr) begin
                #31.25;
                o_sck = ~o_sck;
                #31.25;
            end else begin
                #62.5;
                o_sck = 1'b1;
                #31.25;
            end
        end
    endtask
    task automatic send8(input logic [7:0] v, input int ln, input bit ddr);
        shift({v, 16'h0000}, 8, ln, ddr);
    endtask
    task automatic send24(input logic [23:0] v, input int ln, input bit ddr);
        shift(v, 24, ln, ddr);
    endtask
    // select rises right after the last bit
    task automatic close_frame;
        #62.5;
        o_cs_n = 1'b1;
        #10;
        o_sck = 1'b0;
        o_io = ~o_io;
        #250;
    endtask
endmodule
`default_nettype wire

/* tb/sfw_top_tb_top.sv */
// sfw_top_tb_top.sv: self-checking bench of the write command decoder
// assumes: sfw_host drives the link, the bench plays the memory port
`timescale 1ns/10ps
`default_nettype none
module sfw_top_tb_top import sfw_pkg::*;;
    logic         i_mclk, i_rst_n, latch, i_wr_ready, prot_on;
    wire logic    i_cs_n, i_sck;
    wire logic [3:0] i_io;
    sfw_lane_type proto;
    logic         o_wr_valid, o_cont, o_overrun;
    logic [17:0]  o_wr_addr;
    logic [7:0]   o_wr_data;
    logic [25:0]  got[$], exq[$];
    int           err_total, checked, k;
    sfw_host host_u (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_io(i_io));
    sfw_top #(.BUF_DEPTH(2)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_cs_n(i_cs_n), .i_sck(i_sck), .i_io(i_io), .i_proto(proto),
        .i_write_enable_latch(latch),
        .i_wr_prot(prot_on && o_wr_addr == 18'h3FFFF),
        .i_wr_ready(i_wr_ready), .o_wr_valid(o_wr_valid),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_cont(o_cont),
        .o_overrun(o_overrun));
    // ------------------------------------------------
    // clock, memory port, checks
    // ------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1)
            got.push_back({o_wr_addr, o_wr_data});
    end
    task automatic chk_word(input logic [25:0] g, input logic [25:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: word %h not %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: flag %b not %b", $time, g, e);
        end
    endtask
    task automatic ex(input logic [17:0] a, input logic [7:0] d);
        exq.push_back({a, d});
    endtask
    task automatic match;
        int i;
        for (i = 0; i < got.size() || i < exq.size(); i++)
            chk_word(i < got.size() ? got[i] : 'x,
                     i < exq.size() ? exq[i] : 'z);
        got.delete();
        exq.delete();
    endtask
    // ol of 0 leaves out the opcode
    task automatic xf(input logic [7:0] op, input int ol, input int al,
        input int dl, input bit ddr, input bit m3, input logic [23:0] a,
        input bit hm, input logic [7:0] m, input logic [23:0] d,
        input int nb);
        int i;
        host_u.open_frame(m3);
        if (ol > 0) host_u.send8(op, ol, 1'b0);
        host_u.send24(a, al, ddr);
        if (hm) host_u.send8(m, al, ddr);
        for (i = 0; i < nb; i++) host_u.send8(d[23-8*i -: 8], dl, ddr);
        host_u.close_frame();
        repeat (12) @(posedge i_mclk);
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic s_burst(input bit p);
        @(negedge i_mclk) prot_on = p;
        xf(8'h02, 1, 1, 1, 0, 0, 24'hFFFFFE, 0, 8'h00, 24'h112233, 3);
        ex(18'h3FFFE, 8'h11);
        if (!p) ex(18'h3FFFF, 8'h22);
        ex(18'h00000, 8'h33);
        match;
        @(negedge i_mclk) prot_on = 1'b0;
    endtask
    task automatic s_latch;
        @(negedge i_mclk) latch = 1'b0;
        xf(8'h02, 1, 1, 1, 0, 0, 24'h000010, 0, 8'h00, 24'hAB0000, 1);
        match;
        @(negedge i_mclk) latch = 1'b1;
        xf(8'h02, 1, 1, 1, 0, 0, 24'h000010, 0, 8'h00, 24'hAB0000, 1);
        ex(18'h00010, 8'hAB);
        match;
    endtask
    task automatic s_proto;
        for (k = 2; k <= 4; k += 2) begin
            @(negedge i_mclk) proto = (k == 2) ? sfw_lane2 : sfw_lane4;
            xf(8'h02, k, k, k, 0, 0, 24'h012345, 0, 8'h00, 24'h5A0000, 1);
            ex(18'h12345, 8'h5A);
            match;
        end
        @(negedge i_mclk) proto = sfw_lane1;
    endtask
    task automatic s_ddr;
        xf(8'hDE, 1, 1, 1, 1, 0, 24'h000100, 0, 8'h00, 24'hC33C00, 2);
        ex(18'h00100, 8'hC3);
        ex(18'h00101, 8'h3C);
        match;
        xf(8'hDE, 1, 1, 1, 1, 1, 24'h000100, 0, 8'h00, 24'hC33C00, 2);
        match;
    endtask
    task automatic s_cont;
        logic [7:0] op[4] = '{8'hDA, 8'hA2, 8'hA1, 8'h32};
        int al[4] = '{1, 1, 2, 1};
        int dl[4] = '{1, 2, 2, 4};
        for (k = 0; k < 4; k++) begin
            xf(op[k], 1, al[k], dl[k], 0, 0, 24'h200, 1, 8'hA7, 24'h960000, 1);
            chk_bit(o_cont, 1'b1);
            xf(op[k], 0, al[k], dl[k], 0, 0, 24'h300, 1, 8'h5A, 24'h690000, 1);
            chk_bit(o_cont, 1'b0);
            ex(18'h00200, 8'h96);
            ex(18'h00300, 8'h69);
            match;
        end
        xf(8'hDD, 1, 1, 1, 1, 0, 24'h400, 1, 8'hA7, 24'h0F0000, 1);
        chk_bit(o_cont, 1'b0);
        xf(8'hDD, 1, 1, 1, 1, 0, 24'h401, 1, 8'hA5, 24'hF00000, 1);
        chk_bit(o_cont, 1'b1);
        xf(8'hDD, 0, 1, 1, 1, 0, 24'h402, 1, 8'hA4, 24'h810000, 1);
        chk_bit(o_cont, 1'b0);
        ex(18'h00400, 8'h0F);
        ex(18'h00401, 8'hF0);
        ex(18'h00402, 8'h81);
        match;
    endtask
    task automatic s_stall;
        @(negedge i_mclk) i_wr_ready = 1'b0;
        xf(8'h02, 1, 1, 1, 0, 0, 24'h000500, 0, 8'h00, 24'hDEADBE, 3);
        chk_bit(o_overrun, 1'b1);
        @(negedge i_mclk) i_wr_ready = 1'b1;
        repeat (8) @(posedge i_mclk);
        ex(18'h00500, 8'hDE);
        ex(18'h00501, 8'hAD);
        match;
        xf(8'h02, 1, 1, 1, 0, 0, 24'h000600, 0, 8'h00, 24'h770000, 1);
        chk_bit(o_overrun, 1'b0);
        ex(18'h00600, 8'h77);
        match;
    endtask
    initial begin
        i_rst_n = 1'b0;
        latch = 1'b1;
        i_wr_ready = 1'b1;
        prot_on = 1'b0;
        proto = sfw_lane1;
        err_total = 0;
        checked = 0;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk) i_rst_n = 1'b1;
        repeat (4) @(posedge i_mclk);
        s_burst(1'b0);
        s_burst(1'b1);
        s_latch;
        s_proto;
        s_ddr;
        s_cont;
        s_stall;
        stop_test;
    end
    initial begin
        #300000;
        err_total++;
        stop_test;
    end
endmodule
`default_nettype wire
